// [rtl/ext_pin_int_params.svh]
`ifndef EXT_PIN_INT_PARAMS_SVH
`define EXT_PIN_INT_PARAMS_SVH

// Word offsets on the register bus (byte addresses)
`define OFS_EDGE_SEL_1     8'h00
`define OFS_EDGE_SEL_2     8'h04
`define OFS_INT_ENABLE_1   8'h08
`define OFS_REQ_FLAGS      8'h0c
`define OFS_WAKE_FLAGS     8'h10
`define OFS_EVT_STATUS     8'h14
`define OFS_EVT_CLEAR      8'h18
`define OFS_EVT_ENABLE     8'h1c

// Field positions
`define POS_NMI_EDGE       7
`define POS_DT_EN          7
`define POS_RTC_EN         6
`define POS_WAKE_EN        5
`define POS_DT_FLAG        7
`define POS_RTC_FLAG       6
`define POS_EVT_DT         7
`define POS_EVT_RTC        6
`define POS_EVT_WAKE       5
`define POS_EVT_NMI        4

// Reset values of the writable bits
`define RST_EDGE_SEL_1     8'h00
`define RST_EDGE_SEL_2     8'h00
`define RST_INT_ENABLE_1   8'h00

// Bits that always read back as one
`define ONES_EDGE_SEL_1    8'h70
`define ONES_EDGE_SEL_2    8'hc0
`define ONES_INT_ENABLE_1  8'h10
`define ONES_REQ_FLAGS     8'h30

// Writable masks
`define WMASK_EDGE_SEL_1   8'h8f
`define WMASK_EDGE_SEL_2   8'h3f
`define WMASK_INT_ENABLE_1 8'hef

// Synchroniser depth ahead of the edge compare
`define SYNC_STAGES        2

`endif

// [rtl/ext_pin_int_pkg.sv]
package ext_pin_int_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] wake_vec_t;
  typedef logic [3:0] ext_vec_t;

  // Pin order in the combined detection vector
  typedef enum {
    PIN_EXT0, PIN_EXT1, PIN_EXT2, PIN_EXT3,
    PIN_WAKE0, PIN_WAKE1, PIN_WAKE2, PIN_WAKE3, PIN_WAKE4, PIN_WAKE5,
    PIN_NMI, PIN_COUNT
  } pin_index_t;

endpackage

// [rtl/ext_pin_int.sv]
`timescale 1ns/1ps
`include "ext_pin_int_params.svh"


module ext_pin_int
  import ext_pin_int_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // External pins, asynchronous
  input  wire logic        NMI_PIN,
  input  wire logic [3:0]  EXT_INT_PIN,
  input  wire logic [5:0]  WAKE_PIN,
  // Same-clock event sources, one-cycle pulses
  input  wire logic        RTC_EVENT,
  input  wire logic        DIRECT_TRANS_EVENT,
  // CPU exception logic
  input  wire logic        CPU_INT_MASK,
  output logic             NMI_REQ,
  output logic      [3:0]  EXT_REQ,
  output logic             WAKE_REQ,
  output logic             RTC_REQ,
  output logic             DIRECT_TRANS_REQ,
  // Summary interrupt
  output logic             IRQ_OUT
);

  localparam int NPIN = int'(PIN_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg_byte_t  nmi_ext_edge_select;
  reg_byte_t  wakeup_edge_select;
  reg_byte_t  pin_rtc_trans_int_enable;
  ext_vec_t   ext_req_flag;
  wake_vec_t  wake_req_flag;
  logic       rtc_req_flag;
  logic       dt_req_flag;
  reg_byte_t  evt_status;
  reg_byte_t  evt_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic       bus_req;
  logic       wr_lane0;
  reg_byte_t  wr_byte;
  logic       wr_edge1;
  logic       wr_edge2;
  logic       wr_enable1;
  logic       wr_flags;
  logic       wr_wflags;
  logic       wr_evt_clear;
  logic       wr_evt_enable;

  // Ack rises on the edge that takes the request, so a master sees one wait cycle
  assign bus_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_lane0 = bus_req && WB_WE_I && WB_SEL_I[0];
  assign wr_byte  = WB_DAT_I[7:0];

  assign wr_edge1      = wr_lane0 && (WB_ADR_I == `OFS_EDGE_SEL_1);
  assign wr_edge2      = wr_lane0 && (WB_ADR_I == `OFS_EDGE_SEL_2);
  assign wr_enable1    = wr_lane0 && (WB_ADR_I == `OFS_INT_ENABLE_1);
  assign wr_flags      = wr_lane0 && (WB_ADR_I == `OFS_REQ_FLAGS);
  assign wr_wflags     = wr_lane0 && (WB_ADR_I == `OFS_WAKE_FLAGS);
  assign wr_evt_clear  = wr_lane0 && (WB_ADR_I == `OFS_EVT_CLEAR);
  assign wr_evt_enable = wr_lane0 && (WB_ADR_I == `OFS_EVT_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] edge_sel;
  logic [NPIN-1:0] pin_edge;

  assign pin_raw  = {NMI_PIN, WAKE_PIN, EXT_INT_PIN};
  assign edge_sel = {nmi_ext_edge_select[`POS_NMI_EDGE],
                     wakeup_edge_select[5:0],
                     nmi_ext_edge_select[3:0]};

  // Edges stay masked until prev holds a real synchronised sample, so a pin
  // resting high at release gives no false rising edge
  logic [`SYNC_STAGES:0] warm;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      warm <= '0;
    end else begin
      warm <= {warm[`SYNC_STAGES-1:0], 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic [`SYNC_STAGES-1:0] sync;
      logic                    prev;
      logic                    cur;

      // First stage feeds only the second
      always_ff @(posedge MCLK) begin
        if (RST) begin
          sync <= '0;
        end else begin
          sync <= {sync[`SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end

      assign cur = sync[`SYNC_STAGES-1];

      always_ff @(posedge MCLK) begin
        if (RST) begin
          prev <= 1'b0;
        end else begin
          prev <= cur;
        end
      end

      assign pin_edge[gi] = warm[`SYNC_STAGES] && (edge_sel[gi] ? (cur && !prev)
                                                              : (!cur && prev));
    end
  endgenerate

  logic      nmi_edge;
  ext_vec_t  ext_edge;
  wake_vec_t wake_edge;

  assign nmi_edge  = pin_edge[PIN_NMI];
  assign ext_edge  = pin_edge[PIN_EXT3:PIN_EXT0];
  assign wake_edge = pin_edge[PIN_WAKE5:PIN_WAKE0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge MCLK) begin
    if (RST) begin
      nmi_ext_edge_select <= `RST_EDGE_SEL_1;
    end else if (wr_edge1) begin
      nmi_ext_edge_select <= wr_byte & `WMASK_EDGE_SEL_1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wakeup_edge_select <= `RST_EDGE_SEL_2;
    end else if (wr_edge2) begin
      wakeup_edge_select <= wr_byte & `WMASK_EDGE_SEL_2;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_rtc_trans_int_enable <= `RST_INT_ENABLE_1;
    end else if (wr_enable1) begin
      pin_rtc_trans_int_enable <= wr_byte & `WMASK_INT_ENABLE_1;
    end
  end

  logic     direct_trans_int_en;
  logic     rtc_int_en;
  logic     wake_int_en;
  ext_vec_t ext_int_en;

  assign direct_trans_int_en = pin_rtc_trans_int_enable[`POS_DT_EN];
  assign rtc_int_en          = pin_rtc_trans_int_enable[`POS_RTC_EN];
  assign wake_int_en         = pin_rtc_trans_int_enable[`POS_WAKE_EN];
  assign ext_int_en          = pin_rtc_trans_int_enable[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Request flags: set on event, cleared by writing 0, set wins

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ext_req_flag <= '0;
    end else begin
      // A colliding edge survives the clear so the request is still taken
      ext_req_flag <= (wr_flags ? (ext_req_flag & wr_byte[3:0]) : ext_req_flag)
                      | ext_edge;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wake_req_flag <= '0;
    end else begin
      wake_req_flag <= (wr_wflags ? (wake_req_flag & wr_byte[5:0]) : wake_req_flag)
                       | wake_edge;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rtc_req_flag <= 1'b0;
    end else begin
      rtc_req_flag <= (wr_flags ? (rtc_req_flag & wr_byte[`POS_RTC_FLAG]) : rtc_req_flag)
                      | RTC_EVENT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      dt_req_flag <= 1'b0;
    end else begin
      dt_req_flag <= (wr_flags ? (dt_req_flag & wr_byte[`POS_DT_FLAG]) : dt_req_flag)
                     | DIRECT_TRANS_EVENT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests to the CPU

  // Software is expected to clear only while masked; unmasked clears still
  // leave a colliding request pending through the set-wins flags above.
  logic     unmasked;
  ext_vec_t next_ext_req;
  logic     next_wake_req;
  logic     next_rtc_req;
  logic     next_dt_req;

  assign unmasked      = !CPU_INT_MASK;
  assign next_ext_req  = (ext_req_flag & ext_int_en) & {4{unmasked}};
  assign next_wake_req = (|wake_req_flag) && wake_int_en && unmasked;
  assign next_rtc_req  = rtc_req_flag && rtc_int_en && unmasked;
  assign next_dt_req   = dt_req_flag && direct_trans_int_en && unmasked;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      EXT_REQ          <= '0;
      WAKE_REQ         <= 1'b0;
      RTC_REQ          <= 1'b0;
      DIRECT_TRANS_REQ <= 1'b0;
    end else begin
      EXT_REQ          <= next_ext_req;
      WAKE_REQ         <= next_wake_req;
      RTC_REQ          <= next_rtc_req;
      DIRECT_TRANS_REQ <= next_dt_req;
    end
  end

  // Non-maskable request ignores the mask entirely
  always_ff @(posedge MCLK) begin
    if (RST) begin
      NMI_REQ <= 1'b0;
    end else begin
      NMI_REQ <= nmi_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, clear and enable for the summary interrupt

  reg_byte_t evt_set;

  assign evt_set = {DIRECT_TRANS_EVENT, RTC_EVENT, |wake_edge, nmi_edge, ext_edge};

  always_ff @(posedge MCLK) begin
    if (RST) begin
      evt_status <= '0;
    end else if (wr_evt_clear) begin
      evt_status <= (evt_status & ~wr_byte) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      evt_enable <= '0;
    end else if (wr_evt_enable) begin
      evt_enable <= wr_byte;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(evt_status & evt_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  reg_byte_t rd_byte;

  always_comb begin
    rd_byte = '0;
    case (WB_ADR_I)
      `OFS_EDGE_SEL_1:   rd_byte = nmi_ext_edge_select | `ONES_EDGE_SEL_1;
      `OFS_EDGE_SEL_2:   rd_byte = wakeup_edge_select | `ONES_EDGE_SEL_2;
      `OFS_INT_ENABLE_1: rd_byte = pin_rtc_trans_int_enable | `ONES_INT_ENABLE_1;
      `OFS_REQ_FLAGS:    rd_byte = {dt_req_flag, rtc_req_flag, 2'b00, ext_req_flag}
                                   | `ONES_REQ_FLAGS;
      `OFS_WAKE_FLAGS:   rd_byte = {2'b00, wake_req_flag};
      `OFS_EVT_STATUS:   rd_byte = evt_status;
      `OFS_EVT_ENABLE:   rd_byte = evt_enable;
      default:           rd_byte = '0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // Unmapped and write-only offsets answer with zero
  always_ff @(posedge MCLK) begin
    if (RST) begin
      WB_DAT_O <= '0;
    end else if (bus_req && !WB_WE_I) begin
      WB_DAT_O <= {24'h000000, rd_byte};
    end
  end

endmodule

// [test/ext_pin_int_sva.sv]
`timescale 1ns/1ps
module ext_pin_int_sva (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        NMI_PIN,
  input wire logic        CPU_INT_MASK,
  input wire logic        NMI_REQ,
  input wire logic [3:0]  EXT_REQ,
  input wire logic        WAKE_REQ,
  input wire logic        RTC_REQ,
  input wire logic        DIRECT_TRANS_REQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic wr = WB_CYC_I && WB_STB_I && WB_WE_I;
  ////////////////////////////////////////
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_STB_I))
    else $error("ack without request");
  read_upper_a: assert property (WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits set");
  mask_blocks_a: assert property (CPU_INT_MASK |=> EXT_REQ == 4'h0 && !WAKE_REQ
    && !RTC_REQ && !DIRECT_TRANS_REQ) else $error("masked request passed");
  nmi_pulse_a: assert property (NMI_REQ |=> !NMI_REQ)
    else $error("nmi request not a pulse");
  // Pin moved between the fourth and third sample back
  nmi_cause_a: assert property (NMI_REQ |-> $past(NMI_PIN, 3) != $past(NMI_PIN, 4))
    else $error("nmi request without pin edge");
  ext_hold_a: assert property (EXT_REQ[0] && !CPU_INT_MASK && !wr && !$past(wr)
    |=> EXT_REQ[0]) else $error("request dropped without write");
  rtc_rise_a: assert property ($rose(RTC_REQ) |-> !$past(CPU_INT_MASK))
    else $error("rtc request while masked");
  dt_rise_a: assert property ($rose(DIRECT_TRANS_REQ) |-> !$past(CPU_INT_MASK))
    else $error("transition request while masked");
  cover property (NMI_REQ);
  cover property ($rose(WAKE_REQ));
  cover property (EXT_REQ[0] ##1 CPU_INT_MASK);
endmodule

bind ext_pin_int ext_pin_int_sva u_sva (.*);

// [test/cpu_exc_model.sv]
`timescale 1ns/1ps
module cpu_exc_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic i_bit_sw,
  input  wire logic nmi_req,
  output logic      cpu_mask,
  output int        nmi_taken
);
  // Masked out of reset, as a core enters its handler
  always_ff @(posedge clk) begin
    if (rst)
      cpu_mask <= 1'b1;
    else
      cpu_mask <= i_bit_sw;
  end
  // The I bit is never consulted here
  always_ff @(posedge clk) begin
    if (rst)
      nmi_taken <= 0;
    else if (nmi_req)
      nmi_taken <= nmi_taken + 1;
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ext_pin_int_pkg::*;
  logic        MCLK = 0, RST = 1, cyc = 0, we = 0, rtc_ev = 0, dt_ev = 0, i_sw = 1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [10:0] pins = 11'h0;
  wire logic [31:0] dat_o;
  wire logic [3:0]  ext_req;
  wire logic        ack, nmi_req, wake_req, rtc_req, dt_req, irq, mask;
  int          fail_count = 0, n_compared = 0, nmi_taken;
  always #50 MCLK = ~MCLK;
  // Pin vector follows pin_index_t order
  ext_pin_int u_dut (.MCLK(MCLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .NMI_PIN(pins[10]), .EXT_INT_PIN(pins[3:0]), .WAKE_PIN(pins[9:4]), .RTC_EVENT(rtc_ev),
    .DIRECT_TRANS_EVENT(dt_ev), .CPU_INT_MASK(mask), .NMI_REQ(nmi_req), .EXT_REQ(ext_req),
    .WAKE_REQ(wake_req), .RTC_REQ(rtc_req), .DIRECT_TRANS_REQ(dt_req), .IRQ_OUT(irq));
  cpu_exc_model u_cpu (.clk(MCLK), .rst(RST), .i_bit_sw(i_sw), .nmi_req(nmi_req),
    .cpu_mask(mask), .nmi_taken(nmi_taken));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Event input rides with the request so it lands on the taking edge
  task automatic wb(input logic w, input logic [7:0] a, d, input logic ev = 1'b0);
    @(posedge MCLK);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    rtc_ev <= ev;
    do begin
      @(posedge MCLK);
      rtc_ev <= 0;
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    wb(0, a, 8'h00);
    chk(rdat, {24'h0, e}, "read");
  endtask
  function automatic logic seen(int p, int b);
    return p == 10 ? logic'(nmi_taken != b) : p < 4 ? ext_req[p] : wake_req;
  endfunction
  task automatic step(input int p, input logic v, e);
    int b;
    b = nmi_taken;
    pins[p] <= v;
    repeat (6) @(posedge MCLK);
    chk(seen(p, b), e, "pin request");
    b = nmi_taken;
    i_sw <= 1;
    wb(1, p < 4 ? 8'h0c : 8'h10, 8'h00);
    i_sw <= 0;
    repeat (2) @(posedge MCLK);
    chk(seen(p, b), 0, "cleared request");
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ones [3] = '{8'h70, 8'hc0, 8'h10};
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i), ones[i]);
      wb(1, 8'(4 * i), 8'hff);
      rd(8'(4 * i), 8'hff);
    end
    wb(1, 8'h40, 8'hff);
    rd(8'h40, 8'h00);
  endtask
  task automatic t_edges;
    int sh;
    wb(1, 8'h08, 8'h2f);
    for (int p = 0; p < 11; p++) begin
      for (int pol = 0; pol < 2; pol++) begin
        sh = p == 10 ? 7 : p < 4 ? p : p - 4;
        wb(1, (p < 4 || p == 10) ? 8'h00 : 8'h04, 8'(pol) << sh);
        step(p, 1'b1, pol[0]);
        step(p, 1'b0, !pol[0]);
      end
    end
  endtask
  task automatic t_mask;
    int b;
    wb(1, 8'h00, 8'h00);
    pins[0] <= 1;
    repeat (6) @(posedge MCLK);
    pins[0] <= 0;
    repeat (6) @(posedge MCLK);
    wb(1, 8'h0c, 8'h0f);
    repeat (2) @(posedge MCLK);
    chk(ext_req, 4'h1, "flag kept by writing one");
    i_sw <= 1;
    b = nmi_taken;
    pins[10] <= 1;
    repeat (6) @(posedge MCLK);
    pins[10] <= 0;
    repeat (6) @(posedge MCLK);
    chk(ext_req, 4'h0, "masked request");
    chk(nmi_taken, b + 1, "nmi while masked");
    wb(1, 8'h08, 8'h2e);
    i_sw <= 0;
    repeat (3) @(posedge MCLK);
    chk(ext_req, 4'h0, "disabled request");
    wb(1, 8'h08, 8'h2f);
    repeat (2) @(posedge MCLK);
    chk(ext_req, 4'h1, "re-enabled request");
  endtask
  task automatic t_rtc_dt;
    i_sw <= 1;
    wb(1, 8'h08, 8'h00);
    wb(1, 8'h18, 8'hff);
    i_sw <= 0;
    rtc_ev <= 1;
    dt_ev <= 1;
    @(posedge MCLK);
    rtc_ev <= 0;
    dt_ev <= 0;
    repeat (3) @(posedge MCLK);
    chk({rtc_req, dt_req}, 2'b00, "disabled events");
    i_sw <= 1;
    wb(1, 8'h08, 8'hc0);
    i_sw <= 0;
    repeat (3) @(posedge MCLK);
    chk({rtc_req, dt_req}, 2'b11, "enabled events");
    rd(8'h14, 8'hc0);
    wb(1, 8'h1c, 8'h40);
    repeat (2) @(posedge MCLK);
    chk(irq, 1, "summary raised");
    wb(1, 8'h18, 8'h40);
    repeat (2) @(posedge MCLK);
    chk(irq, 0, "summary cleared");
    rd(8'h14, 8'h80);
    // Clear while unmasked, colliding with a fresh event
    wb(1, 8'h0c, 8'h00, 1'b1);
    repeat (3) @(posedge MCLK);
    chk({rtc_req, dt_req}, 2'b10, "collision kept");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 0;
    i_sw <= 0;
    t_regs();
    t_edges();
    t_mask();
    t_rtc_dt();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge MCLK);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
